/* logic/mbtap_core.v */
// Contract
// [RULE1] Code 00h captures the cell ring and puts the boundary register on the serial path.
// [RULE2] Code 21h loads the fixed identification word and puts that register on the serial path.
// [RULE3] Code 05h captures the cell ring and puts the boundary register on the serial path.
// [RULE4] Code 07h selects the bypass bit while output balls drive the boundary register values.
// [RULE5] Code 03h selects the bypass bit and turns every output ball off.
// [RULE6] Code FFh puts the single bypass bit between serial input and serial output.
// [RULE7] External test, identification and bypass leave the functional ball path untouched.
// [RULE8] The controller loads only the six defined codes; the rest are reserved. The code loads any shifted code into instr_q.
// [RULE9] The identification word holds revision in 31:28, device in 27:12 and vendor in 11:1.
// [RULE10] Bit 0 of the identification word is always 1.
// [RULE11] The chain starts with the data clock cells at 1 and 2, commands at 3 to 5, impedance at 28.
// [RULE12] In the narrow configuration cells 10 to 27 belong to unused balls and hold nothing.
// [RULE13] The instruction register is eight bits, shifted in during the instruction-shift state.
// [RULE14] A shifted instruction takes effect only on entry to the instruction-update state. The code loads instr_q on the rising edge that leaves that state.
// [RULE15] Identification becomes the current instruction at reset and in test-logic-reset.
`timescale 1ns/10ps
`default_nettype none
`include "mbtap_regs.vh"

module mbtap_core #(
   parameter       BSR_LEN   = `MBTAP_BSR_LEN,
   parameter       WIDE_CFG  = 1'b1,
   parameter [3:0]  ID_REV   = 4'h0,
   // Arbitrary neutral values.
   parameter [15:0] ID_DEV   = 16'h5A3C,
   parameter [10:0] ID_VEN   = 11'h155
) (
   // Clock and reset.
   input  wire               ref_clk,
   input  wire               rst_n,
   // Test port pins.
   input  wire               test_clk,
   input  wire               test_mode,
   input  wire               test_in,
   output reg                test_out_q,
   output reg                test_out_oe_q,
   // Ball ring.
   input  wire [BSR_LEN-1:0] ring_in,
   input  wire [BSR_LEN-1:0] core_out,
   input  wire [BSR_LEN-1:0] core_oe,
   output reg  [BSR_LEN-1:0] ball_out_q,
   output reg  [BSR_LEN-1:0] ball_oe_q,
   // Status.
   output reg  [7:0]         instr_q
);

   localparam [15:0] S_TLR  = 16'h0001;
   localparam [15:0] S_RTI  = 16'h0002;
   localparam [15:0] S_SDRS = 16'h0004;
   localparam [15:0] S_CDR  = 16'h0008;
   localparam [15:0] S_SHDR = 16'h0010;
   localparam [15:0] S_E1DR = 16'h0020;
   localparam [15:0] S_PDR  = 16'h0040;
   localparam [15:0] S_E2DR = 16'h0080;
   localparam [15:0] S_UDR  = 16'h0100;
   localparam [15:0] S_SIRS = 16'h0200;
   localparam [15:0] S_CIR  = 16'h0400;
   localparam [15:0] S_SHIR = 16'h0800;
   localparam [15:0] S_E1IR = 16'h1000;
   localparam [15:0] S_PIR  = 16'h2000;
   localparam [15:0] S_E2IR = 16'h4000;
   localparam [15:0] S_UIR  = 16'h8000;

   wire [2:0]         pins;
   reg                tck_prev_q;
   reg  [15:0]        state_q;
   reg  [15:0]        state_d;
   reg  [7:0]         ir_sh_q;
   reg  [31:0]        id_sh_q;
   reg                byp_q;
   reg  [BSR_LEN-1:0] bsr_sh_q;
   reg  [BSR_LEN-1:0] bsr_upd_q;
   wire [BSR_LEN-1:0] ring_cap;
   wire [BSR_LEN-1:0] cell_used;
   wire [31:0]        id_word;
   wire               tck;
   wire               tms;
   wire               tdi;
   wire               tck_rise;
   wire               tck_fall;
   wire               sel_bsr;
   wire               sel_id;
   wire               op_clamp;
   wire               op_highz;

   // The test clock is sampled alongside its mode and data pins so that all
   // three see the same filter delay and stay aligned to each other.
   mbtap_sync #(
      .WIDTH    (3)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in ({test_clk, test_mode, test_in}),
      .level_q  (pins)
   );

   assign tck      = pins[2];
   assign tms      = pins[1];
   assign tdi      = pins[0];
   assign tck_rise = tck & ~tck_prev_q;
   assign tck_fall = ~tck & tck_prev_q;

   // Reserved codes fall through to the bypass path, the least intrusive choice.
   assign sel_bsr  = (instr_q == `MBTAP_OP_EXTEST) ||
                     (instr_q == `MBTAP_OP_SAMPLE);   // see [RULE1] see [RULE3]
   assign sel_id   = (instr_q == `MBTAP_OP_IDCODE);   // see [RULE2]
   assign op_clamp = (instr_q == `MBTAP_OP_CLAMP);
   assign op_highz = (instr_q == `MBTAP_OP_HIGHZ);

   assign id_word[`MBTAP_ID_REV_HI:`MBTAP_ID_REV_LO] = ID_REV;   // see [RULE9]
   assign id_word[`MBTAP_ID_DEV_HI:`MBTAP_ID_DEV_LO] = ID_DEV;   // see [RULE9]
   assign id_word[`MBTAP_ID_VEN_HI:`MBTAP_ID_VEN_LO] = ID_VEN;   // see [RULE9]
   assign id_word[`MBTAP_ID_PRESENT]                 = 1'b1;     // see [RULE10]

   // Cell n of the chain is vector bit n-1, so cell 1 leaves first.
   genvar g;
   generate
      for (g = 0; g < BSR_LEN; g = g + 1) begin : g_cell
         assign cell_used[g] = WIDE_CFG ||
                               (g < `MBTAP_CELL_UNUSED_LO - 1) ||
                               (g > `MBTAP_CELL_UNUSED_HI - 1);   // see [RULE12]
         assign ring_cap[g]  = ring_in[g] & cell_used[g];         // see [RULE11]
      end
   endgenerate

   always @* begin
      state_d = state_q;
      case (state_q)
         S_TLR:   state_d = tms ? S_TLR  : S_RTI;
         S_RTI:   state_d = tms ? S_SDRS : S_RTI;
         S_SDRS:  state_d = tms ? S_SIRS : S_CDR;
         S_CDR:   state_d = tms ? S_E1DR : S_SHDR;
         S_SHDR:  state_d = tms ? S_E1DR : S_SHDR;
         S_E1DR:  state_d = tms ? S_UDR  : S_PDR;
         S_PDR:   state_d = tms ? S_E2DR : S_PDR;
         S_E2DR:  state_d = tms ? S_UDR  : S_SHDR;
         S_UDR:   state_d = tms ? S_SDRS : S_RTI;
         S_SIRS:  state_d = tms ? S_TLR  : S_CIR;
         S_CIR:   state_d = tms ? S_E1IR : S_SHIR;
         S_SHIR:  state_d = tms ? S_E1IR : S_SHIR;
         S_E1IR:  state_d = tms ? S_UIR  : S_PIR;
         S_PIR:   state_d = tms ? S_E2IR : S_PIR;
         S_E2IR:  state_d = tms ? S_UIR  : S_SHIR;
         S_UIR:   state_d = tms ? S_SDRS : S_RTI;
         default: state_d = S_TLR;
      endcase
   end

   // Controller and shift registers advance on the test clock rising edge.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tck_prev_q <= 1'b0;
         state_q    <= S_TLR;
         instr_q    <= `MBTAP_OP_IDCODE;
         ir_sh_q    <= `MBTAP_IR_CAPTURE;
         id_sh_q    <= 32'h0000_0000;
         byp_q      <= 1'b0;
         bsr_sh_q   <= {BSR_LEN{1'b0}};
         bsr_upd_q  <= {BSR_LEN{1'b0}};
      end else begin
         tck_prev_q <= tck;
         if (tck_rise) begin
            state_q <= state_d;
            case (state_q)
               S_TLR: begin
                  instr_q <= `MBTAP_OP_IDCODE;   // see [RULE15]
               end
               S_CIR: begin
                  ir_sh_q <= `MBTAP_IR_CAPTURE;
               end
               S_SHIR: begin
                  ir_sh_q <= {tdi, ir_sh_q[7:1]};   // see [RULE13]
               end
               S_UIR: begin
                  instr_q <= ir_sh_q;   // see [RULE14]
               end
               S_CDR: begin
                  if (sel_bsr) begin
                     bsr_sh_q <= ring_cap;   // see [RULE1] see [RULE3]
                  end else if (sel_id) begin
                     id_sh_q <= id_word;   // see [RULE2]
                  end else begin
                     byp_q <= 1'b0;
                  end
               end
               S_SHDR: begin
                  if (sel_bsr) begin
                     bsr_sh_q <= {tdi, bsr_sh_q[BSR_LEN-1:1]};
                  end else if (sel_id) begin
                     id_sh_q <= {tdi, id_sh_q[31:1]};
                  end else begin
                     byp_q <= tdi;   // see [RULE4] see [RULE5] see [RULE6]
                  end
               end
               S_UDR: begin
                  if (sel_bsr) begin
                     bsr_upd_q <= bsr_sh_q;
                  end
               end
               default: begin
                  byp_q <= byp_q;
               end
            endcase
         end
      end
   end

   // Serial output changes on the falling edge and drives only while shifting.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_out_q    <= 1'b0;
         test_out_oe_q <= 1'b0;
      end else if (tck_fall) begin
         test_out_oe_q <= (state_q == S_SHDR) || (state_q == S_SHIR);
         if (state_q == S_SHIR) begin
            test_out_q <= ir_sh_q[0];
         end else if (sel_bsr) begin
            test_out_q <= bsr_sh_q[0];
         end else if (sel_id) begin
            test_out_q <= id_sh_q[0];
         end else begin
            test_out_q <= byp_q;
         end
      end
   end

   // The balls follow the core except under clamp and high impedance.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ball_out_q <= {BSR_LEN{1'b0}};
         ball_oe_q  <= {BSR_LEN{1'b0}};
      end else if (op_highz) begin
         ball_out_q <= core_out;
         ball_oe_q  <= {BSR_LEN{1'b0}};   // see [RULE5]
      end else if (op_clamp) begin
         ball_out_q <= bsr_upd_q & cell_used;   // see [RULE4]
         ball_oe_q  <= core_oe & cell_used;
      end else begin
         ball_out_q <= core_out;   // see [RULE7]
         ball_oe_q  <= core_oe;    // see [RULE7]
      end
   end

endmodule

`default_nettype wire

/* logic/mbtap_regs.vh */
`ifndef MBTAP_REGS_VH
`define MBTAP_REGS_VH

// Register lengths.
`define MBTAP_IR_LEN        8
`define MBTAP_ID_LEN        32
`define MBTAP_BSR_LEN       113

// Instruction codes.
`define MBTAP_OP_EXTEST     8'h00
`define MBTAP_OP_IDCODE     8'h21
`define MBTAP_OP_SAMPLE     8'h05
`define MBTAP_OP_CLAMP      8'h07
`define MBTAP_OP_HIGHZ      8'h03
`define MBTAP_OP_BYPASS     8'hFF

// Fixed pattern loaded into the instruction shifter on capture.
`define MBTAP_IR_CAPTURE    8'h01

// Identification word fields.
`define MBTAP_ID_REV_HI     31
`define MBTAP_ID_REV_LO     28
`define MBTAP_ID_DEV_HI     27
`define MBTAP_ID_DEV_LO     12
`define MBTAP_ID_VEN_HI     11
`define MBTAP_ID_VEN_LO     1
`define MBTAP_ID_PRESENT    0

// Scan cell numbers, counted from 1; cell n sits at vector bit n-1.
`define MBTAP_CELL_DK       1
`define MBTAP_CELL_DK_N     2
`define MBTAP_CELL_CS       3
`define MBTAP_CELL_REF      4
`define MBTAP_CELL_WE       5
`define MBTAP_CELL_UNUSED_LO 10
`define MBTAP_CELL_UNUSED_HI 27
`define MBTAP_CELL_ZQ       28

`endif

/* logic/mbtap_sync.v */
`timescale 1ns/10ps
`default_nettype none

module mbtap_sync #(
   parameter WIDTH = 3
) (
   // Clock and reset.
   input  wire             ref_clk,
   input  wire             rst_n,
   // Asynchronous inputs and their filtered levels.
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] level_q
);

   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   integer         i;

   // A bit only moves once the second and third stages agree, which rejects
   // a one-cycle glitch at the cost of one extra cycle of latency.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q    <= {WIDTH{1'b0}};
         s2_q    <= {WIDTH{1'b0}};
         s3_q    <= {WIDTH{1'b0}};
         level_q <= {WIDTH{1'b0}};
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

/* verification/mbtap_core_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module mbtap_core_chk #(
   parameter BSR_LEN = 113
) (
   // Clock and reset.
   input wire logic               ref_clk,
   input wire logic               rst_n,
   // Test port.
   input wire logic               test_clk,
   input wire logic               test_out_q,
   input wire logic               test_out_oe_q,
   input wire logic [7:0]         instr_q,
   // Ball ring.
   input wire logic [BSR_LEN-1:0] core_out,
   input wire logic [BSR_LEN-1:0] core_oe,
   input wire logic [BSR_LEN-1:0] ball_out_q,
   input wire logic [BSR_LEN-1:0] ball_oe_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] quiet_q;
   logic       pin_q;
   // Cycles since the test clock pin last moved; by nine the pin filter has long settled.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_q <= 4'h0;
         pin_q <= 1'h0;
      end else begin
         pin_q <= test_clk;
         quiet_q <= (test_clk != pin_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
      end
   end
   sequence clamp_held_s;
      instr_q == 8'h07 ##1 instr_q == 8'h07;
   endsequence
   rst_id_a: assert property ($rose(rst_n) |-> instr_q == 8'h21)
      else $error("no id after reset");
   rst_idle_a: assert property ($rose(rst_n) |-> ball_oe_q == '0 && !test_out_oe_q)
      else $error("active after reset");
   func_path_a: assert property (!(instr_q inside {8'h03, 8'h07}) |=>
      ball_out_q == $past(core_out) && ball_oe_q == $past(core_oe)) else $error("path disturbed");
   highz_oe_a: assert property (instr_q == 8'h03 |=> ball_oe_q == '0)
      else $error("ball driven in high-z");
   clamp_oe_a: assert property (instr_q == 8'h07 |=> ball_oe_q == $past(core_oe))
      else $error("clamp enables wrong");
   clamp_hold_a: assert property (clamp_held_s |=> $stable(ball_out_q))
      else $error("clamp values moved");
   ir_update_a: assert property ($changed(instr_q) |-> !test_out_oe_q)
      else $error("instruction changed in shift");
   pin_quiet_a: assert property (quiet_q > 4'h8 |-> $stable(instr_q) && $stable(test_out_q))
      else $error("moved without test clock");
endmodule
bind mbtap_core mbtap_core_chk #(.BSR_LEN(BSR_LEN)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .test_clk(test_clk), .test_out_q(test_out_q),
   .test_out_oe_q(test_out_oe_q), .instr_q(instr_q), .core_out(core_out),
   .core_oe(core_oe), .ball_out_q(ball_out_q), .ball_oe_q(ball_oe_q)
);
`default_nettype wire

/* verification/mbtap_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mbtap_ctl_model (
   // Clock.
   input  wire logic ref_clk,
   // Test port.
   output var  logic test_clk,
   output var  logic test_mode,
   output var  logic test_in,
   input  wire logic test_out_q
);
   initial begin
      test_clk = 1'h0;
      test_mode = 1'h1;
      test_in = 1'h0;
   end
   // A 200 ns period; the pin rests low between calls, so no edge falls outside a frame.
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      @(posedge ref_clk);
      test_mode <= tms;
      test_in <= tdi;
      repeat (3) @(posedge ref_clk);
      test_clk <= 1'h1;
      repeat (4) @(posedge ref_clk);
      tdo = test_out_q;
      test_clk <= 1'h0;
   endtask
   // Idle ticks invert the data pin so a stale level is never mistaken for data.
   task automatic scan(input logic ir, input int n, input logic [112:0] din,
                       output logic [112:0] dout);
      logic b;
      dout = '0;
      tick(1'h1, ~test_in, b);
      if (ir) tick(1'h1, ~test_in, b);
      tick(1'h0, ~test_in, b);
      tick(1'h0, ~test_in, b);
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
      tick(1'h1, ~test_in, b);
      tick(1'h0, ~test_in, b);
   endtask
   task automatic reset_port();
      logic b;
      repeat (5) tick(1'h1, ~test_in, b);
      tick(1'h0, ~test_in, b);
   endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int N = 113;
   // Arbitrary identification values.
   localparam logic [31:0] ID_WORD = {4'h9, 16'hC3A5, 11'h2B4, 1'h1};
   logic         ref_clk, rst_n, test_clk, test_mode, test_in, test_out_q, test_out_oe_q;
   logic [N-1:0] ring_in, core_out, core_oe, ball_out_q, ball_oe_q, got, pat, held, exp;
   logic [7:0]   instr_q;
   logic [7:0]   codes [7] = '{8'h00, 8'h21, 8'h05, 8'h07, 8'h03, 8'hFF, 8'h5A};
   int           errors, num_checks;
   mbtap_core #(.BSR_LEN(N), .ID_REV(4'h9), .ID_DEV(16'hC3A5), .ID_VEN(11'h2B4)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .test_clk(test_clk), .test_mode(test_mode),
      .test_in(test_in), .test_out_q(test_out_q), .test_out_oe_q(test_out_oe_q),
      .ring_in(ring_in), .core_out(core_out), .core_oe(core_oe),
      .ball_out_q(ball_out_q), .ball_oe_q(ball_oe_q), .instr_q(instr_q));
   mbtap_ctl_model u_ctl (.ref_clk(ref_clk), .test_clk(test_clk), .test_mode(test_mode),
      .test_in(test_in), .test_out_q(test_out_q));
   task automatic check(input string what, input logic [N-1:0] seen, input logic [N-1:0] want);
      num_checks++;
      if (seen !== want) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic final_report();
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // About a thousand test clock periods are planned; twice that ends a hang.
   initial begin
      #400000;
      errors++;
      final_report();
   end
   initial begin
      rst_n = 1'h0;
      errors = 0;
      num_checks = 0;
      core_out = N'({29{4'h3}});
      core_oe = N'({29{4'h6}});
      ring_in = '0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'h1;
      u_ctl.reset_port();
      u_ctl.scan(1'h0, 32, '0, got);
      check("id_word", got, N'(ID_WORD));
      foreach (codes[k]) begin
         core_out <= {core_out[N-2:0], ~core_out[N-1]};
         core_oe <= ~core_oe;
         ring_in <= ~core_out;
         u_ctl.scan(1'h1, 8, N'(codes[k]), got);
         repeat (3) @(posedge ref_clk);
         check("ir_capture", got, N'(8'h01));
         check("instr", N'(instr_q), N'(codes[k]));
         pat = core_out ^ N'({29{4'hC}});
         u_ctl.scan(1'h0, N, pat, got);
         if (codes[k] == 8'h00 || codes[k] == 8'h05) exp = ring_in;
         else if (codes[k] == 8'h21) exp = {pat[N-33:0], ID_WORD};
         else exp = {pat[N-2:0], 1'h0};
         check("dr_path", got, exp);
         if (codes[k] == 8'h05) held = pat;
         repeat (12) @(posedge ref_clk);
         exp = (codes[k] == 8'h07) ? held : core_out;
         if (codes[k] != 8'h03) check("ball_out", ball_out_q, exp);
         exp = (codes[k] == 8'h03) ? '0 : core_oe;
         check("ball_oe", ball_oe_q, exp);
      end
      u_ctl.reset_port();
      repeat (3) @(posedge ref_clk);
      check("instr_reset", N'(instr_q), N'(8'h21));
      final_report();
   end
endmodule
`default_nettype wire
